/* design/ddcd_pkg.sv */
// Constants, command codes and carrier types of the dual DAC command decoder
// What this block does
// RL1: Code 0000 changes nothing: input registers, DAC registers and sleep state kept.
// RL2: Code 0001 loads input register A only; nothing else changes.
// RL3: Code 0010 loads input register B only; nothing else changes.
// RL4: Code 1000 copies both input registers into DAC registers and wakes.
// RL5: Code 1001 loads input A, then transfers both input registers and wakes.
// RL6: Code 1010 loads input B, then transfers both input registers and wakes.
// RL7: Code 1101 wakes only; outputs show existing DAC registers again.
// RL8: Code 1110 sleeps, keeps all registers, puts both outputs high impedance.
// RL9: Code 1111 loads both inputs with one code, transfers both, wakes.
// RL10: Reserved codes 0011-0111, 1011, 1100 do nothing at all.
// RL11: The operation runs once, at select rising after 16 bits, never while shifting.
// RL12: Word is 4 control bits, 10 code bits MSB first, 2 pad bits.
// RL13: Shift clock ignored while select is high; host keeps it low at select fall.
// RL14: Sleep keeps logic alive; input registers still load and apply at the next update.
// RL15: Reset clears the input, DAC and sleep registers so outputs start at zero scale.
package ddcd_pkg;

    localparam int unsigned WORD_BITS  = 16;
    localparam int unsigned CODE_BITS  = 10;
    localparam int unsigned CTRL_BITS  = 4;
    localparam int unsigned CNT_BITS   = 5;

    // Field positions inside the shifted word, first bit shifted lands at the top
    localparam int unsigned CTRL_MSB   = 15;
    localparam int unsigned CTRL_LSB   = 12;
    localparam int unsigned DATA_MSB   = 11;
    localparam int unsigned DATA_LSB   = 2;

    localparam logic [CNT_BITS-1:0]  FULL_COUNT = 5'h10;
    localparam logic [CODE_BITS-1:0] ZERO_SCALE = 10'h000;

    // Control codes
    localparam logic [CTRL_BITS-1:0] CMD_NOP      = 4'h0;
    localparam logic [CTRL_BITS-1:0] CMD_LOAD_A   = 4'h1;
    localparam logic [CTRL_BITS-1:0] CMD_LOAD_B   = 4'h2;
    localparam logic [CTRL_BITS-1:0] CMD_UPDATE   = 4'h8;
    localparam logic [CTRL_BITS-1:0] CMD_LOAD_A_U = 4'h9;
    localparam logic [CTRL_BITS-1:0] CMD_LOAD_B_U = 4'ha;
    localparam logic [CTRL_BITS-1:0] CMD_WAKE     = 4'hd;
    localparam logic [CTRL_BITS-1:0] CMD_SLEEP    = 4'he;
    localparam logic [CTRL_BITS-1:0] CMD_LOAD_ALL = 4'hf;

    typedef struct packed {
        logic [CODE_BITS-1:0] a;
        logic [CODE_BITS-1:0] b;
    } ddcd_pair_s;

    typedef struct packed {
        logic load_a;
        logic load_b;
        logic update;
        logic wake;
        logic sleep;
    } ddcd_action_s;

endpackage

/* design/ddcd_top.sv */
// Dual DAC command decoder: serial shift on the link clock, decode on the system clock
`timescale 1ns/10ps
module ddcd_top
    import ddcd_pkg::*;
(
    // System
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Serial link pins
    input  wire logic             shift_clock,
    input  wire logic             select_and_commit_n,
    input  wire logic             serial_data_in,
    // Converter side
    output ddcd_pair_s            dac_codes,
    output ddcd_pair_s            input_codes,
    output logic                  outputs_hiz,
    output logic                  commit_pulse
);

    // Link domain: shift register and an edge toggle
    logic [WORD_BITS-1:0] shift_q;
    logic [WORD_BITS-1:0] shift_d;
    logic                 edge_tog_q;
    logic                 edge_tog_d;

    always_comb begin
        shift_d    = shift_q;
        edge_tog_d = edge_tog_q;
        if (!select_and_commit_n) begin // [RL13]
            shift_d    = {shift_q[WORD_BITS-2:0], serial_data_in}; // [RL12]
            edge_tog_d = ~edge_tog_q;
        end
    end

    // The link clock stops between frames, so its reset cannot wait for an edge
    always_ff @(posedge shift_clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_q    <= 16'h0000;
            edge_tog_q <= 1'b0;
        end else begin
            shift_q    <= shift_d;
            edge_tog_q <= edge_tog_d;
        end
    end

    // System domain: synchronisers
    logic sel_m_q;
    logic sel_s_q;
    logic sel_prev_q;
    logic tog_m_q;
    logic tog_s_q;
    logic tog_seen_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sel_m_q    <= 1'b1;
            sel_s_q    <= 1'b1;
            sel_prev_q <= 1'b1;
            tog_m_q    <= 1'b0;
            tog_s_q    <= 1'b0;
            tog_seen_q <= 1'b0;
        end else begin
            sel_m_q    <= select_and_commit_n;
            sel_s_q    <= sel_m_q;
            sel_prev_q <= sel_s_q;
            tog_m_q    <= edge_tog_q;
            tog_s_q    <= tog_m_q;
            tog_seen_q <= tog_s_q;
        end
    end

    // Bit counting and commit detection
    logic [CNT_BITS-1:0] cnt_q;
    logic [CNT_BITS-1:0] cnt_d;
    logic [CNT_BITS-1:0] cnt_inc;
    logic                bit_seen;
    logic                sel_rise;
    logic                commit;

    always_comb begin
        bit_seen = tog_s_q ^ tog_seen_q;
        sel_rise = sel_s_q & ~sel_prev_q;
        cnt_inc  = cnt_q;
        if (bit_seen && (cnt_q < FULL_COUNT)) begin
            cnt_inc = CNT_BITS'(cnt_q + 5'h01);
        end
        // Word is only taken whole, and only on the select rising edge
        commit = sel_rise & (cnt_inc == FULL_COUNT); // [RL11]
        cnt_d  = cnt_inc;
        if (sel_s_q) begin
            cnt_d = 5'h00;
        end
    end

    function automatic ddcd_action_s decode_cmd(input logic [CTRL_BITS-1:0] code);
        ddcd_action_s act;
        act = '0;
        case (code)
            CMD_LOAD_A:   act.load_a = 1'b1;                                    // [RL2]
            CMD_LOAD_B:   act.load_b = 1'b1;                                    // [RL3]
            CMD_UPDATE:   begin act.update = 1'b1; act.wake = 1'b1; end          // [RL4]
            CMD_LOAD_A_U: begin act.load_a = 1'b1; act.update = 1'b1; act.wake = 1'b1; end // [RL5]
            CMD_LOAD_B_U: begin act.load_b = 1'b1; act.update = 1'b1; act.wake = 1'b1; end // [RL6]
            CMD_WAKE:     act.wake = 1'b1;                                      // [RL7]
            CMD_SLEEP:    act.sleep = 1'b1;                                     // [RL8]
            CMD_LOAD_ALL: act = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};                 // [RL9]
            default:      act = '0;                                             // [RL1] [RL10]
        endcase
        return act;
    endfunction

    // Register state
    ddcd_pair_s           in_q;
    ddcd_pair_s           in_d;
    ddcd_pair_s           dac_q;
    ddcd_pair_s           dac_d;
    logic                 sleep_q;
    logic                 sleep_d;
    logic                 commit_q;
    logic [CTRL_BITS-1:0] ctrl_word;
    logic [CODE_BITS-1:0] data_word;
    ddcd_action_s         act;

    always_comb begin
        ctrl_word = shift_q[CTRL_MSB:CTRL_LSB]; // [RL12]
        data_word = shift_q[DATA_MSB:DATA_LSB];
        act       = decode_cmd(ctrl_word);
        in_d      = in_q;
        dac_d     = dac_q;
        sleep_d   = sleep_q;
        if (commit) begin
            // Loads act in sleep too and wait for a later update
            if (act.load_a) begin
                in_d.a = data_word; // [RL14]
            end
            if (act.load_b) begin
                in_d.b = data_word;
            end
            if (act.update) begin
                dac_d = in_d;
            end
            if (act.wake) begin
                sleep_d = 1'b0;
            end else if (act.sleep) begin
                sleep_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            in_q     <= '{ZERO_SCALE, ZERO_SCALE}; // [RL15]
            dac_q    <= '{ZERO_SCALE, ZERO_SCALE};
            sleep_q  <= 1'b0;
            commit_q <= 1'b0;
            cnt_q    <= 5'h00;
        end else begin
            in_q     <= in_d;
            dac_q    <= dac_d;
            sleep_q  <= sleep_d;
            commit_q <= commit;
            cnt_q    <= cnt_d;
        end
    end

    assign dac_codes    = dac_q;
    assign input_codes  = in_q;
    assign outputs_hiz  = sleep_q;
    assign commit_pulse = commit_q;

    // Checks
    property p_nop;
        @(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_NOP) |=> $stable(in_q) && $stable(dac_q) && $stable(sleep_q);
    endproperty
    a_nop: assert property (p_nop) else $error("No-op changed state"); // [RL1]

    property p_load_a;
        @(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_LOAD_A) |=>
            (in_q.a == $past(data_word)) && $stable(in_q.b) && $stable(dac_q) && $stable(sleep_q);
    endproperty
    a_load_a: assert property (p_load_a) else $error("Load A wrong"); // [RL2]

    property p_load_b;
        @(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_LOAD_B) |=>
            (in_q.b == $past(data_word)) && $stable(in_q.a) && $stable(dac_q) && $stable(sleep_q);
    endproperty
    a_load_b: assert property (p_load_b) else $error("Load B wrong"); // [RL3]

    property p_update;
        @(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_UPDATE) |=> (dac_q == $past(in_q)) && $stable(in_q) && !sleep_q;
    endproperty
    a_update: assert property (p_update) else $error("Update wrong"); // [RL4]

    property p_load_a_u;
        @(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_LOAD_A_U) |=>
            (dac_q.a == $past(data_word)) && (dac_q.b == $past(in_q.b)) && (in_q == dac_q) && !sleep_q;
    endproperty
    a_load_a_u: assert property (p_load_a_u) else $error("Load A and update wrong"); // [RL5]

    property p_load_b_u;
        @(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_LOAD_B_U) |=>
            (dac_q.b == $past(data_word)) && (dac_q.a == $past(in_q.a)) && (in_q == dac_q) && !sleep_q;
    endproperty
    a_load_b_u: assert property (p_load_b_u) else $error("Load B and update wrong"); // [RL6]

    property p_wake;
        @(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_WAKE) |=> !outputs_hiz && $stable(in_q) && $stable(dac_q);
    endproperty
    a_wake: assert property (p_wake) else $error("Wake wrong"); // [RL7]

    property p_sleep;
        @(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_SLEEP) |=> outputs_hiz && $stable(in_q) && $stable(dac_q);
    endproperty
    a_sleep: assert property (p_sleep) else $error("Sleep wrong"); // [RL8]

    property p_load_all;
        @(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_LOAD_ALL) |=> (dac_q.a == $past(data_word))
            && (dac_q.b == $past(data_word)) && (in_q == dac_q) && !sleep_q;
    endproperty
    a_load_all: assert property (p_load_all) else $error("Load both wrong"); // [RL9]

    property p_reserved;
        @(posedge clock) disable iff (!rst_n)
        commit && (act == '0) |=> $stable(in_q) && $stable(dac_q) && $stable(sleep_q);
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved code acted"); // [RL10]

    property p_only_commit;
        @(posedge clock) disable iff (!rst_n)
        !commit |=> $stable(in_q) && $stable(dac_q) && $stable(sleep_q) && !commit_pulse;
    endproperty
    a_only_commit: assert property (p_only_commit) else $error("State moved without commit"); // [RL11]

    property p_single;
        @(posedge clock) disable iff (!rst_n)
        commit |=> !commit [*3];
    endproperty
    a_single: assert property (p_single) else $error("Word executed twice"); // [RL11]

    property p_idle_link;
        @(posedge shift_clock) disable iff (!rst_n)
        select_and_commit_n |=> $stable(shift_q);
    endproperty
    a_idle_link: assert property (p_idle_link) else $error("Shifted while deselected"); // [RL13]

    c_sleep_load: cover property (@(posedge clock) disable iff (!rst_n)
        sleep_q && commit && (ctrl_word == CMD_LOAD_A));
    c_wake_update: cover property (@(posedge clock) disable iff (!rst_n)
        sleep_q && commit && (ctrl_word == CMD_UPDATE));
    c_load_all: cover property (@(posedge clock) disable iff (!rst_n)
        commit && (ctrl_word == CMD_LOAD_ALL));
    c_short_word: cover property (@(posedge clock) disable iff (!rst_n)
        sel_rise && !commit);

endmodule

/* tb/ddcd_host.sv */
// Host model that drives the three-wire serial link of the decoder
`timescale 1ns/10ps
module ddcd_host (
    // Serial link pins
    output logic shift_clock,
    output logic select_and_commit_n,
    output logic serial_data_in
);
    initial begin
        shift_clock         = 1'b0;
        select_and_commit_n = 1'b1;
        serial_data_in      = 1'b1;
    end

    // Shifts the low n bits of w, top bit first; ends at the select rise
    task automatic send(input logic [31:0] w, input int n);
        #3.3;
        select_and_commit_n = 1'b0;
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in = w[i];
            #62.5 shift_clock = 1'b1;
            #62.5 shift_clock = 1'b0;
        end
        #30 select_and_commit_n = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask

    // Shift clock edges while deselected; they must be ignored
    task automatic stray(input int n);
        repeat (n) begin
            serial_data_in = ~serial_data_in;
            #62.5 shift_clock = 1'b1;
            #62.5 shift_clock = 1'b0;
        end
    endtask
endmodule

/* tb/tb.sv */
// Self-checking testbench of the dual DAC command decoder
`timescale 1ns/10ps
module tb;
    import ddcd_pkg::*;
    logic       clock;
    logic       rst_n;
    logic       shift_clock;
    logic       select_and_commit_n;
    logic       serial_data_in;
    ddcd_pair_s dac_codes;
    ddcd_pair_s input_codes;
    logic       outputs_hiz;
    logic       commit_pulse;
    ddcd_pair_s exp_in;
    ddcd_pair_s exp_dac;
    logic       exp_hiz;
    int         err_total;
    int         tests_run;

    ddcd_host host (
        .shift_clock         (shift_clock),
        .select_and_commit_n (select_and_commit_n),
        .serial_data_in      (serial_data_in)
    );

    ddcd_top uut (
        .clock               (clock),
        .rst_n               (rst_n),
        .shift_clock         (shift_clock),
        .select_and_commit_n (select_and_commit_n),
        .serial_data_in      (serial_data_in),
        .dac_codes           (dac_codes),
        .input_codes         (input_codes),
        .outputs_hiz         (outputs_hiz),
        .commit_pulse        (commit_pulse)
    );

    initial clock = 1'b0;
    always #5 clock = ~clock;

    task automatic test_done();
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk20(input ddcd_pair_s got, input ddcd_pair_s exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_state();
        chk20(dac_codes, exp_dac);
        chk20(input_codes, exp_in);
        chk1(outputs_hiz, exp_hiz);
    endtask

    // Expected effect of one whole word on the registers
    function automatic void model(input logic [15:0] w);
        logic [3:0] c;
        logic [9:0] d;
        c = w[15:12];
        d = w[11:2];
        if (c inside {CMD_LOAD_A, CMD_LOAD_A_U, CMD_LOAD_ALL})
            exp_in.a = d;
        if (c inside {CMD_LOAD_B, CMD_LOAD_B_U, CMD_LOAD_ALL})
            exp_in.b = d;
        if (c inside {CMD_UPDATE, CMD_LOAD_A_U, CMD_LOAD_B_U, CMD_LOAD_ALL})
            exp_dac = exp_in;
        if (c inside {CMD_UPDATE, CMD_LOAD_A_U, CMD_LOAD_B_U, CMD_LOAD_ALL, CMD_WAKE})
            exp_hiz = 1'b0;
        else if (c == CMD_SLEEP)
            exp_hiz = 1'b1;
    endfunction

    // Counts commit cycles after a frame; a whole word gives exactly one
    task automatic expect_commit(input logic want);
        int hits;
        hits = 0;
        repeat (14) begin
            @(posedge clock);
            #1;
            if (commit_pulse === 1'b1)
                hits++;
        end
        chk1(hits == 1, want);
    endtask

    task automatic do_word(input logic [31:0] w, input int n);
        @(negedge clock);
        host.send(w, n);
        if (n >= 16)
            model(w[15:0]);
        expect_commit(n >= 16);
        check_state();
    endtask

    initial begin
        // About three times the expected run length
        #400_000;
        err_total++;
        test_done();
    end

    initial begin
        err_total = 0;
        tests_run = 0;
        exp_in    = '0;
        exp_dac   = '0;
        exp_hiz   = 1'b0;
        rst_n     = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        void'($urandom(32'hec34e574));
        check_state();
        $display("test reset done");
        for (int c = 0; c < 16; c++)
            do_word({16'h0, 4'(c), 10'($urandom), 2'b11}, 16);
        $display("test all codes done");
        do_word({16'h0, CMD_SLEEP, 10'h3ff, 2'b00}, 16);
        do_word({16'h0, CMD_LOAD_A, 10'h3ff, 2'b01}, 16);
        do_word({16'h0, CMD_LOAD_B, 10'h000, 2'b10}, 16);
        do_word({16'h0, CMD_UPDATE, 10'h155, 2'b00}, 16);
        do_word({16'h0, CMD_SLEEP, 10'h000, 2'b11}, 16);
        do_word({16'h0, CMD_WAKE, 10'h2aa, 2'b00}, 16);
        $display("test sleep and wake done");
        do_word({16'h0, CMD_LOAD_ALL, 10'h3ff, 2'b00}, 15);
        do_word({15'h0, 1'b1, CMD_LOAD_ALL, 10'h201, 2'b00}, 17);
        @(negedge clock);
        host.stray(6);
        expect_commit(1'b0);
        check_state();
        $display("test framing done");
        repeat (30)
            do_word({16'h0, 16'($urandom)}, 16);
        $display("test random words done");
        test_done();
    end
endmodule
